// ==== hw/pcl_pkg.sv ====
// Package of constants for the control-line and interrupt logic
package pcl_pkg;
    localparam int CTL_W = 8;
    localparam int BIT_C1_IRQ_EN = 0;
    localparam int BIT_C1_RISE = 1;
    localparam int BIT_DDR_ACCESS = 2;
    localparam int BIT_C2_IRQ_EN = 3;
    localparam int BIT_C2_RISE = 4;
    localparam int BIT_C2_OUT = 5;
    localparam int BIT_FLAG2 = 6;
    localparam int BIT_FLAG1 = 7;
    localparam logic [2:0] MODE_HSHAKE = 3'h4;
    localparam logic [2:0] MODE_PULSE = 3'h5;
    localparam logic [2:0] MODE_LOW = 3'h6;
    localparam logic [2:0] MODE_HIGH = 3'h7;
    localparam logic [1:0] RS_DATA = 2'h0;
    localparam logic [1:0] RS_CTL_A = 2'h1;
    localparam logic [1:0] RS_CTL_B = 2'h3;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam int SYNC_STAGES = 3;
endpackage

// ==== hw/pcl_edge_sync.sv ====
// Three-stage pin synchroniser with polarity-selectable edge detector
`timescale 1ns/1ps
module pcl_edge_sync
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    input wire logic rise_sel_i,
    output logic level_o,
    output logic edge_o
);
    import pcl_pkg::*;
    logic [SYNC_STAGES-1:0] sync_ff;
    logic [SYNC_STAGES-1:0] nxt_sync;
    logic level_ff;
    logic nxt_level;

    always_comb
    begin
        nxt_sync = {sync_ff[SYNC_STAGES-2:0], pin_i};
        nxt_level = level_ff;
        if (sync_ff[1] == sync_ff[2])
        begin
            nxt_level = sync_ff[1];
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            sync_ff <= '0;
            level_ff <= 1'b0;
        end
        else
        begin
            sync_ff <= nxt_sync;
            level_ff <= nxt_level;
        end
    end

    assign level_o = level_ff;
    assign edge_o = rise_sel_i ? (nxt_level & ~level_ff)
                               : (~nxt_level & level_ff);
endmodule

// ==== hw/pcl_irq_logic.sv ====
// Control-line and interrupt logic for the two ports of the adapter
// Functional notes
// - Strobe edge of chosen polarity sets flag 7
// - Flag 7 with bit 0 pulls irq low
// - Aux input edge sets flag 6 only while bit 5 is clear
// - Flag 6 with bit 3 and bit 5 clear pulls irq low
// - Port A handshake: strobe edge drives aux high
// - Port A handshake: data read drives aux low
// - Port A pulse: one-cycle low after read
// - Port B handshake: data write drives aux low
// - Port B handshake: strobe edge drives aux high
// - Port B pulse: one-cycle low after write
// - Data read clears both flags of the port read
// - Data read needs select zero and bit 2
`timescale 1ns/1ps
module pcl_irq_logic
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic bus_sel_i,
    input wire logic bus_rd_i,
    input wire logic bus_wr_i,
    input wire logic port_b_sel_i,
    input wire logic reg_select_hi_i,
    input wire logic reg_select_lo_i,
    input wire logic [pcl_pkg::CTL_W-1:0] wdata_i,
    output logic [pcl_pkg::CTL_W-1:0] rdata_o,
    input wire logic port_a_strobe_in_i,
    input wire logic port_b_strobe_in_i,
    input wire logic port_a_aux_line_i,
    input wire logic port_b_aux_line_i,
    output logic port_a_aux_line_o,
    output logic port_a_aux_line_oe_o,
    output logic port_b_aux_line_o,
    output logic port_b_aux_line_oe_o,
    output logic port_a_irq_n_o,
    output logic port_b_irq_n_o
);
    import pcl_pkg::*;

    // Index 0 is port A, index 1 is port B
    logic [CTL_W-1:0] ctl_ff [2];
    logic [CTL_W-1:0] nxt_ctl [2];
    logic [1:0] aux_ff;
    logic [1:0] nxt_aux;
    logic [1:0] oe_ff;
    logic [1:0] nxt_oe;
    logic [1:0] irq_n_ff;
    logic [1:0] nxt_irq_n;
    logic [CTL_W-1:0] rdata_ff;
    logic [CTL_W-1:0] nxt_rdata;
    logic [1:0] c1_edge;
    logic [1:0] c2_edge;
    logic [1:0] data_rd;
    logic [1:0] data_wr;
    logic [1:0] strobe_pin;
    logic [1:0] aux_pin;

    default clocking cb_main @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    function automatic logic [2:0] aux_mode(input logic [CTL_W-1:0] c);
        aux_mode = c[BIT_C2_OUT:BIT_C2_IRQ_EN];
    endfunction

    function automatic logic [1:0] sel_rs();
        sel_rs = {reg_select_hi_i, reg_select_lo_i};
    endfunction

    assign strobe_pin = {port_b_strobe_in_i, port_a_strobe_in_i};
    assign aux_pin = {port_b_aux_line_i, port_a_aux_line_i};

    for (genvar p = 0; p < 2; p++)
    begin : g_port
        pcl_edge_sync u_c1
        (
            .sys_clk_i(sys_clk_i),
            .rst_n_i(rst_n_i),
            .pin_i(strobe_pin[p]),
            .rise_sel_i(ctl_ff[p][BIT_C1_RISE]),
            .level_o(),
            .edge_o(c1_edge[p])
        );
        pcl_edge_sync u_c2
        (
            .sys_clk_i(sys_clk_i),
            .rst_n_i(rst_n_i),
            .pin_i(aux_pin[p]),
            .rise_sel_i(ctl_ff[p][BIT_C2_RISE]),
            .level_o(),
            .edge_o(c2_edge[p])
        );
    end

    always_comb
    begin
        nxt_rdata = rdata_ff;
        for (int p = 0; p < 2; p++)
        begin
            // Data register only when bit 2 selects it
            data_rd[p] = bus_sel_i && bus_rd_i && (sel_rs() == RS_DATA)
                && (port_b_sel_i == p[0])
                && ctl_ff[p][BIT_DDR_ACCESS];
            data_wr[p] = bus_sel_i && bus_wr_i && (sel_rs() == RS_DATA)
                && (port_b_sel_i == p[0])
                && ctl_ff[p][BIT_DDR_ACCESS];
            nxt_ctl[p] = ctl_ff[p];
            if (bus_sel_i && bus_wr_i
                && sel_rs() == (p == 0 ? RS_CTL_A : RS_CTL_B))
            begin
                nxt_ctl[p][5:0] = wdata_i[5:0];
            end
            if (data_rd[p])
            begin
                nxt_ctl[p][BIT_FLAG1] = 1'b0;
                nxt_ctl[p][BIT_FLAG2] = 1'b0;
            end
            // Set wins over the read clear
            if (c1_edge[p])
            begin
                nxt_ctl[p][BIT_FLAG1] = 1'b1;
            end
            if (c2_edge[p] && !ctl_ff[p][BIT_C2_OUT])
            begin
                nxt_ctl[p][BIT_FLAG2] = 1'b1;
            end
            nxt_irq_n[p] = ~((nxt_ctl[p][BIT_FLAG1]
                && nxt_ctl[p][BIT_C1_IRQ_EN])
                || (nxt_ctl[p][BIT_FLAG2]
                && nxt_ctl[p][BIT_C2_IRQ_EN]
                && !nxt_ctl[p][BIT_C2_OUT]));
            nxt_oe[p] = nxt_ctl[p][BIT_C2_OUT];
            nxt_aux[p] = aux_ff[p];
            case (aux_mode(nxt_ctl[p]))
                MODE_HSHAKE:
                begin
                    if (c1_edge[p])
                    begin
                        nxt_aux[p] = 1'b1;
                    end
                    else if (p == 0 && data_rd[p])
                    begin
                        nxt_aux[p] = 1'b0;
                    end
                    else if (p == 1 && data_wr[p])
                    begin
                        nxt_aux[p] = 1'b0;
                    end
                end
                MODE_PULSE:
                begin
                    nxt_aux[p] = !((p == 0) ? data_rd[p]
                        : data_wr[p]);
                end
                MODE_LOW: nxt_aux[p] = 1'b0;
                MODE_HIGH: nxt_aux[p] = 1'b1;
                default: nxt_aux[p] = 1'b1;
            endcase
        end
        if (bus_sel_i && bus_rd_i && sel_rs() == RS_CTL_A)
        begin
            nxt_rdata = ctl_ff[0];
        end
        else if (bus_sel_i && bus_rd_i && sel_rs() == RS_CTL_B)
        begin
            nxt_rdata = ctl_ff[1];
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            ctl_ff[0] <= CTL_RESET;
            ctl_ff[1] <= CTL_RESET;
            aux_ff <= 2'h3;
            oe_ff <= 2'h0;
            irq_n_ff <= 2'h3;
            rdata_ff <= 8'h00;
        end
        else
        begin
            ctl_ff <= nxt_ctl;
            aux_ff <= nxt_aux;
            oe_ff <= nxt_oe;
            irq_n_ff <= nxt_irq_n;
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_o = rdata_ff;
    assign port_a_aux_line_o = aux_ff[0];
    assign port_b_aux_line_o = aux_ff[1];
    assign port_a_aux_line_oe_o = oe_ff[0];
    assign port_b_aux_line_oe_o = oe_ff[1];
    assign port_a_irq_n_o = irq_n_ff[0];
    assign port_b_irq_n_o = irq_n_ff[1];

    // Checks
    flag1_set_a: assert property (
        c1_edge[0] |=> ctl_ff[0][BIT_FLAG1])
        else $error("primary flag not set");
    irq_enable_a: assert property (
        (ctl_ff[0][BIT_FLAG1] && ctl_ff[0][BIT_C1_IRQ_EN]) |-> !irq_n_ff[0])
        else $error("irq not asserted");
    flag2_set_a: assert property (
        (c2_edge[1] && !ctl_ff[1][BIT_C2_OUT]) |=> ctl_ff[1][BIT_FLAG2])
        else $error("secondary flag not set");
    irq_idle_a: assert property (
        !(ctl_ff[1][BIT_FLAG1] && ctl_ff[1][BIT_C1_IRQ_EN])
        && !(ctl_ff[1][BIT_FLAG2] && ctl_ff[1][BIT_C2_IRQ_EN])
        |-> irq_n_ff[1]) else $error("irq low with no flag");
    a_pulse_a: assert property (
        (data_rd[0] && aux_mode(nxt_ctl[0]) == MODE_PULSE)
        |=> !aux_ff[0]) else $error("pulse low missing");
    pulse_end_a: assert property (
        (!data_rd[0] && aux_mode(nxt_ctl[0]) == MODE_PULSE)
        |=> aux_ff[0]) else $error("pulse longer than one cycle");
    b_hshake_a: assert property (
        (data_wr[1] && !c1_edge[1] && aux_mode(ctl_ff[1]) == MODE_HSHAKE)
        |=> !aux_ff[1]) else $error("no handshake low");
    rd_clear_a: assert property (
        (data_rd[0] && !c1_edge[0]) |=> !ctl_ff[0][BIT_FLAG1])
        else $error("flag not cleared");
    manual_a: assert property (
        aux_mode(ctl_ff[1]) == MODE_LOW |-> !aux_ff[1])
        else $error("manual low not held");
    cov_irq_c: cover property (@(posedge sys_clk_i) !irq_n_ff[0]);
    cov_hs_c: cover property (@(posedge sys_clk_i)
        aux_mode(ctl_ff[0]) == MODE_HSHAKE && data_rd[0]);
    cov_pulse_c: cover property (@(posedge sys_clk_i)
        aux_mode(ctl_ff[1]) == MODE_PULSE && data_wr[1]);
endmodule

// ==== testbench/pcl_periph_model.sv ====
// Peripheral model that answers on the strobe and aux lines
`timescale 1ns/1ps
module pcl_periph_model
(
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic [1:0] kick_i,
    input wire logic [1:0] drv_i,
    input wire logic [1:0] aux_i,
    input wire logic [1:0] oe_i,
    output logic [1:0] strb_o,
    output logic [1:0] wire_o
);
    logic [1:0] prev = 2'h3;
    int hold [2] = '{0, 0};
    initial strb_o = 2'h3;
    assign wire_o = (oe_i & aux_i) | (~oe_i & drv_i);
    always @(posedge clk_i)
    begin
        for (int i = 0; i < 2; i++)
        begin
            // Pulse the strobe when kicked or when port B aux falls
            if (kick_i[i] || (i == 1 && oe_i[1] && prev[1] && !aux_i[1]))
                hold[i] = slow_i ? 32 : 8;
            strb_o[i] <= !(hold[i] > 0 && hold[i] <= (slow_i ? 16 : 6));
            if (hold[i] > 0)
                hold[i]--;
            prev[i] <= aux_i[i];
        end
    end
endmodule

// ==== testbench/pcl_irq_logic_tb_top.sv ====
// Testbench for the control-line and interrupt logic
`timescale 1ns/1ps
`define CHK(a, e) \
    begin \
        cmp_count++; \
        if ((a) !== (e)) \
        begin \
            miscompares++; \
            $display("wrong value t=%0t got %h exp %h", $time, a, e); \
        end \
    end
module pcl_irq_logic_tb_top;
    import pcl_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sel = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic pb = 1'b0;
    logic slow = 1'b0;
    logic [1:0] rs = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [1:0] kick = 2'h0;
    logic [1:0] drv = 2'h3;
    logic [1:0] aux_o, aux_oe, strb, auxw, irq;
    int miscompares = 0;
    int cmp_count = 0;

    always #25 clk = ~clk;

    pcl_irq_logic u_dut
    (
        .sys_clk_i(clk),
        .rst_n_i(rst_n),
        .bus_sel_i(sel),
        .bus_rd_i(rd),
        .bus_wr_i(wr),
        .port_b_sel_i(pb),
        .reg_select_hi_i(rs[1]),
        .reg_select_lo_i(rs[0]),
        .wdata_i(wdata),
        .rdata_o(rdata),
        .port_a_strobe_in_i(strb[0]),
        .port_b_strobe_in_i(strb[1]),
        .port_a_aux_line_i(auxw[0]),
        .port_b_aux_line_i(auxw[1]),
        .port_a_aux_line_o(aux_o[0]),
        .port_a_aux_line_oe_o(aux_oe[0]),
        .port_b_aux_line_o(aux_o[1]),
        .port_b_aux_line_oe_o(aux_oe[1]),
        .port_a_irq_n_o(irq[0]),
        .port_b_irq_n_o(irq[1])
    );

    pcl_periph_model u_periph
    (
        .clk_i(clk),
        .slow_i(slow),
        .kick_i(kick),
        .drv_i(drv),
        .aux_i(aux_o),
        .oe_i(aux_oe),
        .strb_o(strb),
        .wire_o(auxw)
    );

    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic acc(input logic [1:0] r, input int p, input logic d_rd,
        input logic [7:0] d);
        @(negedge clk);
        rs = r;
        pb = p[0];
        rd = d_rd;
        wr = !d_rd;
        wdata = d;
        sel = 1'b1;
        @(negedge clk);
        sel = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
    endtask

    task automatic ctl(input int p, input logic [7:0] v);
        acc(p ? RS_CTL_B : RS_CTL_A, p, 1'b0, v);
        wt(2);
    endtask

    task automatic rdc(input int p, input logic [7:0] e);
        acc(p ? RS_CTL_B : RS_CTL_A, p, 1'b1, 8'h00);
        wt(1);
        `CHK(rdata, e)
    endtask

    task automatic kk(input int p, input int n);
        kick[p] = 1'b1;
        @(negedge clk);
        kick = 2'h0;
        wt(n);
    endtask

    task automatic pc(input int p, input logic r);
        int lows;
        acc(RS_DATA, p, r, 8'h5a);
        lows = !aux_o[p];
        repeat (5)
        begin
            @(negedge clk);
            lows += !aux_o[p];
        end
        `CHK(lows[3:0], 4'h1)
    endtask

    task automatic t_reset;
        `CHK({irq, aux_oe}, 4'hc)
        rdc(0, CTL_RESET);
        rdc(1, CTL_RESET);
    endtask

    task automatic t_primary(input int p);
        ctl(p, 8'h00);
        kk(p, 12);
        `CHK(irq[p], 1'b1)
        rdc(p, 8'h80);
        ctl(p, 8'h01);
        `CHK(irq[p], 1'b0)
        acc(RS_DATA, p, 1'b1, 8'h00);
        wt(2);
        `CHK(irq[p], 1'b0)
        ctl(p, 8'h05);
        acc(RS_DATA, p, 1'b1, 8'h00);
        wt(2);
        `CHK(irq[p], 1'b1)
        rdc(p, 8'h05);
        slow = 1'b1;
        ctl(p, 8'h03);
        kk(p, 24);
        `CHK(irq[p], 1'b1)
        wt(16);
        `CHK(irq[p], 1'b0)
        slow = 1'b0;
    endtask

    task automatic t_secondary(input int p);
        ctl(p, 8'h0c);
        acc(RS_DATA, p, 1'b1, 8'h00);
        drv[p] = 1'b0;
        wt(8);
        `CHK(irq[p], 1'b0)
        rdc(p, 8'h4c);
        ctl(p, 8'h14);
        acc(RS_DATA, p, 1'b1, 8'h00);
        drv[p] = 1'b1;
        wt(8);
        `CHK(irq[p], 1'b1)
        rdc(p, 8'h54);
    endtask

    task automatic t_hs_a;
        ctl(0, 8'h24);
        acc(RS_DATA, 0, 1'b1, 8'h00);
        wt(2);
        `CHK({aux_oe[0], aux_o[0]}, 2'h2)
        kk(0, 12);
        `CHK(aux_o[0], 1'b1)
    endtask

    task automatic t_hs_b;
        ctl(1, 8'h24);
        for (int s = 0; s < 2; s++)
        begin
            slow = s[0];
            acc(RS_DATA, 1, 1'b0, 8'h3c);
            wt(1);
            `CHK(aux_o[1], 1'b0)
            wt(40);
            `CHK(aux_o[1], 1'b1)
        end
        slow = 1'b0;
    endtask

    task automatic t_manual;
        for (int p = 0; p < 2; p++)
        begin
            ctl(p, 8'h30);
            kk(p, 12);
            `CHK({aux_oe[p], aux_o[p]}, 2'h2)
            ctl(p, 8'h38);
            `CHK({aux_oe[p], aux_o[p]}, 2'h3)
        end
    endtask

    task automatic final_report;
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        wt(4);
        rst_n = 1'b1;
        wt(6);
        t_reset();
        for (int p = 0; p < 2; p++)
        begin
            t_primary(p);
            t_secondary(p);
        end
        t_hs_a();
        ctl(0, 8'h2c);
        pc(0, 1'b1);
        t_hs_b();
        ctl(1, 8'h2c);
        pc(1, 1'b0);
        t_manual();
        final_report();
    end

    initial
    begin
        #200000;
        miscompares++;
        final_report();
    end
endmodule
